// File: logic/tss_params.svh
// constants for the tape sense status link
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH

// command codes
`define TSS_CMD_READ 8'h04
`define TSS_CMD_RD_FM 8'h05
`define TSS_CMD_STATUS 8'h06
`define TSS_CMD_REWIND 8'h07
`define TSS_CMD_RETEN 8'h08
`define TSS_CMD_ERASE 8'h09
`define TSS_CMD_UNLOAD 8'h0C
`define TSS_CMD_CONT 8'h14
`define TSS_CMD_WR_RAM 8'h15
`define TSS_CMD_RD_RAM 8'h16
`define TSS_CMD_VERIFY 8'h17
`define TSS_CMD_EOT 8'h80

// drive_error_status bit positions
`define TSS_E_BLK_NF 0
`define TSS_E_LEN 1
`define TSS_E_CMD 3
`define TSS_E_PROTO 4
`define TSS_E_NO_DATA 5
`define TSS_E_BOT 6

// track_and_position_status bit positions
`define TSS_P_TRK_LO 0
`define TSS_P_TRK_HI 3
`define TSS_P_FM 5
`define TSS_P_EOT 6

// block number split
`define TSS_BLK_LO_HI 7
`define TSS_BLK_HI_LO 8
`define TSS_BLK_HI_HI 11

// reserved sense bit positions
`define TSS_RSV_B2 2
`define TSS_RSV_B4 4
`define TSS_BYTE_MSB 7

// sense frame
`define TSS_NUM_BYTES 4
`define TSS_LAST_IDX 2'h3
`define TSS_ZERO8 8'h00

// host side timing and drive quirks
`define TSS_CLK_MHZ 100
`define TSS_EOT_WAIT_MS 200
`define TSS_CYC_PER_MS (`TSS_CLK_MHZ * 1000)
`define TSS_QRK_A_LO 16'h0100
`define TSS_QRK_A_HI 16'h01FE
`define TSS_QRK_B_LO 16'h0300
`define TSS_QRK_B_HI 16'h03FE
`define TSS_QRK_ADD 16'h0200
`define TSS_LAST_BLK 16'hFFFF
`define TSS_EXTRA_BYTES 16'h0800

`endif

// File: logic/tss_pkg.sv
// types shared by both ends of the sense status link
`default_nettype none
package tss_pkg;

    typedef enum logic {
        TSS_DRV_STREAM = 1'b0,
        TSS_DRV_BLOCK = 1'b1
    } tss_drive_t;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b01,
        DS_SEND = 2'b10
    } tss_dev_state_t;

    typedef enum logic [4:0] {
        HS_IDLE = 5'b00001,
        HS_WAIT = 5'b00010,
        HS_CMD = 5'b00100,
        HS_STAT = 5'b01000,
        HS_RECV = 5'b10000
    } tss_host_state_t;

endpackage : tss_pkg
`default_nettype wire

// File: logic/tss_link_if.sv
// command and sense byte link between host and tape interface
`timescale 1ns/1ns
`default_nettype none
interface tss_link_if;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_ready;
    logic sts_valid;
    logic [7:0] sts_data;
    logic sts_last;
    logic sts_ready;

    modport dev (
        input cmd_valid, cmd_data, sts_ready,
        output cmd_ready, sts_valid, sts_data, sts_last
    );

    modport hst (
        output cmd_valid, cmd_data, sts_ready,
        input cmd_ready, sts_valid, sts_data, sts_last
    );
endinterface : tss_link_if
`default_nettype wire

// File: logic/tss_dev.sv
// tape interface end: collects drive events and returns sense bytes
`timescale 1ns/1ns
`default_nettype none
`include "tss_params.svh"

// Behaviour
// R1: block or header missing sets error bit0
// R2: drive-ended transfer sets length bit1
// R3: invalid drive command sets bit3
// R4: protocol break or unsupported command sets bit4
// R5: no block or mark timeout sets bit5
// R6: rewound to beginning sets bit6
// R7: file mark detected sets byte3 bit5
// R8: logical end of tape sets byte3 bit6
// R9: block number low byte in byte4
// R10: host trusts read block number only with mark
// R11: block bits 8-11 in byte5 low
// R12: streaming unknown-length read waits before end
// R13: second type, status after mark untrusted
// R14: second type readback count plus 200h
// R15: second type final block accepts extra bytes
// R16: track number binary in byte3 bits0-3
// R17: reserved sense bits always read zero
// R18: host reads sense bytes after every command
// R19: status request 06h returns sense bytes
module tss_dev
    import tss_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // host link
    tss_link_if.dev link,
    // drive configuration
    input wire logic drive_type_i,
    // drive event pulses
    input wire logic blk_not_found_i,
    input wire logic blk_no_follow_i,
    input wire logic drive_ended_xfer_i,
    input wire logic invalid_cmd_i,
    input wire logic protocol_err_i,
    input wire logic no_data_timeout_i,
    input wire logic bot_logical_i,
    input wire logic bot_physical_i,
    input wire logic file_mark_i,
    input wire logic eot_logical_i,
    // drive position
    input wire logic op_done_i,
    input wire logic [3:0] track_i,
    input wire logic [11:0] block_i,
    // command seen by the drive logic
    output logic cmd_stb_o,
    output logic [7:0] cmd_o
);

    tss_dev_state_t state_r;
    tss_dev_state_t state_nxt;
    logic cmd_ready_r;
    logic sts_valid_r;
    logic [7:0] sts_data_r;
    logic sts_last_r;
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    logic [7:0] err_r;
    logic [7:0] err_nxt;
    logic [7:0] pos_r;
    logic [7:0] pos_nxt;
    logic [11:0] blk_r;
    logic [3:0] trk_r;
    logic [7:0] snap_r [`TSS_NUM_BYTES];
    logic cmd_stb_r;
    logic [7:0] cmd_r;

    // decode of the incoming command
    wire cmd_take = link.cmd_valid & cmd_ready_r;
    wire is_status = (link.cmd_data == `TSS_CMD_STATUS);
    wire stream_only = (link.cmd_data == `TSS_CMD_RD_FM) |
                       (link.cmd_data == `TSS_CMD_REWIND) |
                       (link.cmd_data == `TSS_CMD_RETEN) |
                       (link.cmd_data == `TSS_CMD_ERASE);
    wire block_only = (link.cmd_data == `TSS_CMD_UNLOAD) |
                      (link.cmd_data == `TSS_CMD_CONT) |
                      (link.cmd_data == `TSS_CMD_WR_RAM) |
                      (link.cmd_data == `TSS_CMD_RD_RAM) |
                      (link.cmd_data == `TSS_CMD_VERIFY);
    wire unsupported = cmd_take &
        ((drive_type_i == TSS_DRV_STREAM) ? block_only : stream_only);
    // a command pushed while a status frame is going out breaks protocol
    wire cmd_in_send = link.cmd_valid & (state_r == DS_SEND);
    // a new working command starts a fresh status picture
    wire clr_flags = cmd_take & ~is_status;
    wire byte_go = sts_valid_r & link.sts_ready;
    wire last_go = byte_go & sts_last_r;
    wire bot_evt = (drive_type_i == TSS_DRV_STREAM) ?
                   bot_logical_i : bot_physical_i; // R6

    // event sets, each one bit of its byte
    wire [7:0] err_set;
    assign err_set[`TSS_E_BLK_NF] = blk_not_found_i | blk_no_follow_i; // R1
    assign err_set[`TSS_E_LEN] = drive_ended_xfer_i; // R2
    assign err_set[`TSS_RSV_B2] = 1'b0; // R17
    assign err_set[`TSS_E_CMD] = invalid_cmd_i; // R3
    assign err_set[`TSS_E_PROTO] =
        protocol_err_i | unsupported | cmd_in_send; // R4
    assign err_set[`TSS_E_NO_DATA] = no_data_timeout_i; // R5
    assign err_set[`TSS_E_BOT] = bot_evt; // R6
    assign err_set[`TSS_BYTE_MSB] = 1'b0; // R17

    wire [7:0] pos_set;
    assign pos_set[`TSS_P_TRK_HI:`TSS_P_TRK_LO] = 4'h0;
    assign pos_set[`TSS_RSV_B4] = 1'b0; // R17
    assign pos_set[`TSS_P_FM] = file_mark_i; // R7
    assign pos_set[`TSS_P_EOT] = eot_logical_i; // R8
    assign pos_set[`TSS_BYTE_MSB] = 1'b0; // R17

    // set wins over the clear so an event on the clearing edge stays
    assign err_nxt = (clr_flags ? `TSS_ZERO8 : err_r) | err_set;
    assign pos_nxt = (clr_flags ? `TSS_ZERO8 : pos_r) | pos_set;

    // sense bytes as they would be sent now
    wire [7:0] sense_b2 = err_r;
    wire [7:0] sense_b3 = {pos_r[`TSS_BYTE_MSB:`TSS_RSV_B4], trk_r}; // R16
    wire [7:0] sense_b4 = blk_r[`TSS_BLK_LO_HI:0]; // R9
    wire [7:0] sense_b5 =
        {4'h0, blk_r[`TSS_BLK_HI_HI:`TSS_BLK_HI_LO]}; // R11 R17

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        case (state_r)
            DS_IDLE: begin
                if (cmd_take && is_status) begin
                    state_nxt = DS_SEND; // R19
                    idx_nxt = 2'h0;
                end
            end
            DS_SEND: begin
                if (last_go) begin
                    state_nxt = DS_IDLE;
                end else if (byte_go) begin
                    idx_nxt = idx_r + 2'h1;
                end
            end
            default: begin
                state_nxt = DS_IDLE;
                idx_nxt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= DS_IDLE;
            idx_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            err_r <= `TSS_ZERO8;
            pos_r <= `TSS_ZERO8;
        end else begin
            err_r <= err_nxt;
            pos_r <= pos_nxt;
        end
    end

    // position is taken once the operation has finished
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            blk_r <= 12'h000;
            trk_r <= 4'h0;
        end else if (op_done_i) begin
            blk_r <= block_i; // R9 R11
            trk_r <= track_i; // R16
        end
    end

    // frame snapshot keeps the four bytes coherent while they go out
    genvar gi;
    generate
        for (gi = 0; gi < `TSS_NUM_BYTES; gi = gi + 1) begin : g_snap
            wire [7:0] src = (gi == 0) ? sense_b2 :
                             (gi == 1) ? sense_b3 :
                             (gi == 2) ? sense_b4 : sense_b5;
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    snap_r[gi] <= `TSS_ZERO8;
                end else if (cmd_take && is_status) begin
                    snap_r[gi] <= src; // R19
                end
            end
        end
    endgenerate

    // link outputs
    wire sending_nxt = (state_nxt == DS_SEND);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cmd_ready_r <= 1'b0;
            sts_valid_r <= 1'b0;
            sts_data_r <= `TSS_ZERO8;
            sts_last_r <= 1'b0;
        end else begin
            cmd_ready_r <= ~sending_nxt;
            sts_valid_r <= (state_r == DS_SEND) & sending_nxt;
            sts_data_r <= snap_r[idx_nxt];
            sts_last_r <= (idx_nxt == `TSS_LAST_IDX);
        end
    end

    // drive-side copy of working commands
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cmd_stb_r <= 1'b0;
            cmd_r <= `TSS_ZERO8;
        end else begin
            cmd_stb_r <= clr_flags;
            if (clr_flags) begin
                cmd_r <= link.cmd_data;
            end
        end
    end

    assign link.cmd_ready = cmd_ready_r;
    assign link.sts_valid = sts_valid_r;
    assign link.sts_data = sts_data_r;
    assign link.sts_last = sts_last_r;
    assign cmd_stb_o = cmd_stb_r;
    assign cmd_o = cmd_r;

endmodule : tss_dev
`default_nettype wire

// File: logic/tss_host.sv
// host end: issues commands and gathers sense bytes after each one
`timescale 1ns/1ns
`default_nettype none
`include "tss_params.svh"

module tss_host
    import tss_pkg::*;
#(
    parameter int EOT_WAIT_CYC = `TSS_EOT_WAIT_MS * `TSS_CYC_PER_MS
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // host link
    tss_link_if.hst link,
    // user request
    input wire logic req_valid_i,
    input wire logic [7:0] req_cmd_i,
    input wire logic drive_type_i,
    input wire logic unknown_len_i,
    output logic req_ready_o,
    // sense result
    output logic sense_valid_o,
    output logic [7:0] sense_err_o,
    output logic [7:0] sense_pos_o,
    output logic [11:0] sense_blk_o,
    output logic blk_trusted_o,
    output logic sense_untrusted_o,
    // drive quirk helpers
    input wire logic [15:0] wr_count_i,
    input wire logic [15:0] wr_block_i,
    output logic [15:0] exp_count_o,
    output logic extra_ok_o
);

    tss_host_state_t state_r;
    logic [24:0] wait_r;
    logic [7:0] cmd_r;
    logic cmd_valid_r;
    logic [7:0] cmd_data_r;
    logic sts_ready_r;
    logic [1:0] idx_r;
    logic [7:0] rx_r [`TSS_NUM_BYTES];
    logic sense_valid_r;
    logic blk_trusted_r;
    logic untrusted_r;
    logic [15:0] exp_count_r;
    logic extra_ok_r;

    wire take = req_valid_i & (state_r == HS_IDLE);
    wire need_wait = (req_cmd_i == `TSS_CMD_EOT) & unknown_len_i &
                     (drive_type_i == TSS_DRV_STREAM); // R12
    wire cmd_go = cmd_valid_r & link.cmd_ready;
    wire rx_go = sts_ready_r & link.sts_valid;
    wire rx_end = rx_go & link.sts_last;
    wire was_read = (cmd_r == `TSS_CMD_READ);
    wire fm_now = rx_r[1][`TSS_P_FM];
    wire in_a = (wr_count_i >= `TSS_QRK_A_LO) & (wr_count_i <= `TSS_QRK_A_HI);
    wire in_b = (wr_count_i >= `TSS_QRK_B_LO) & (wr_count_i <= `TSS_QRK_B_HI);
    wire qrk = (drive_type_i == TSS_DRV_BLOCK) & (in_a | in_b);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= HS_IDLE;
            wait_r <= 25'h0000000;
            cmd_r <= `TSS_ZERO8;
            cmd_valid_r <= 1'b0;
            cmd_data_r <= `TSS_ZERO8;
            sts_ready_r <= 1'b0;
            idx_r <= 2'h0;
        end else begin
            case (state_r)
                HS_IDLE: begin
                    if (take) begin
                        cmd_r <= req_cmd_i;
                        cmd_data_r <= req_cmd_i;
                        wait_r <= 25'(EOT_WAIT_CYC);
                        cmd_valid_r <= ~need_wait;
                        state_r <= need_wait ? HS_WAIT : HS_CMD;
                    end
                end
                HS_WAIT: begin
                    wait_r <= wait_r - 25'h0000001; // R12
                    if (wait_r <= 25'h0000001) begin
                        cmd_valid_r <= 1'b1;
                        state_r <= HS_CMD;
                    end
                end
                HS_CMD: begin
                    if (cmd_go) begin
                        // every command is followed by a status read
                        cmd_data_r <= `TSS_CMD_STATUS; // R18
                        cmd_valid_r <= (cmd_r != `TSS_CMD_STATUS);
                        sts_ready_r <= (cmd_r == `TSS_CMD_STATUS);
                        idx_r <= 2'h0;
                        state_r <= (cmd_r == `TSS_CMD_STATUS) ?
                                   HS_RECV : HS_STAT;
                    end
                end
                HS_STAT: begin
                    if (cmd_go) begin
                        cmd_valid_r <= 1'b0;
                        sts_ready_r <= 1'b1;
                        state_r <= HS_RECV;
                    end
                end
                HS_RECV: begin
                    if (rx_go) begin
                        idx_r <= idx_r + 2'h1;
                    end
                    if (rx_end) begin
                        sts_ready_r <= 1'b0;
                        state_r <= HS_IDLE;
                    end
                end
                default: begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TSS_NUM_BYTES; gi = gi + 1) begin : g_rx
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    rx_r[gi] <= `TSS_ZERO8;
                end else if (rx_go && (idx_r == 2'(gi))) begin
                    rx_r[gi] <= link.sts_data;
                end
            end
        end
    endgenerate

    // report two cycles after the last byte, once all four are held
    logic done_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
            sense_valid_r <= 1'b0;
            blk_trusted_r <= 1'b0;
            untrusted_r <= 1'b0;
            exp_count_r <= 16'h0000;
            extra_ok_r <= 1'b0;
        end else begin
            done_r <= rx_end;
            sense_valid_r <= done_r;
            if (done_r) begin
                blk_trusted_r <= ~was_read | fm_now; // R10
                untrusted_r <= was_read & fm_now &
                    (drive_type_i == TSS_DRV_BLOCK); // R13
            end
            exp_count_r <= qrk ? wr_count_i + `TSS_QRK_ADD : wr_count_i; // R14
            extra_ok_r <= (drive_type_i == TSS_DRV_BLOCK) &
                          (wr_block_i == `TSS_LAST_BLK); // R15
        end
    end

    assign link.cmd_valid = cmd_valid_r;
    assign link.cmd_data = cmd_data_r;
    assign link.sts_ready = sts_ready_r;
    assign req_ready_o = (state_r == HS_IDLE);
    assign sense_valid_o = sense_valid_r;
    assign sense_err_o = rx_r[0];
    assign sense_pos_o = rx_r[1];
    assign sense_blk_o = {rx_r[3][3:0], rx_r[2]};
    assign blk_trusted_o = blk_trusted_r;
    assign sense_untrusted_o = untrusted_r;
    assign exp_count_o = exp_count_r;
    assign extra_ok_o = extra_ok_r;

endmodule : tss_host
`default_nettype wire

// File: bench/tss_link_sva.sv
// assertions on the command and sense byte link
`timescale 1ns/1ns
`default_nettype none
module tss_link_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ready,
    input wire logic sts_valid,
    input wire logic [7:0] sts_data,
    input wire logic sts_last,
    input wire logic sts_ready
);
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    wire byte_take = sts_valid & sts_ready;
    // position inside the frame, so reserved bits are checked per byte
    assign idx_nxt = sts_last ? 2'h0 : idx_r + 2'h1;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) idx_r <= 2'h0;
        else if (byte_take) idx_r <= idx_nxt;
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_stat_take;
        cmd_valid && cmd_ready && cmd_data == 8'h06;
    endsequence
    sequence s_frame_open;
        !cmd_ready ##1 sts_valid && idx_r == 2'h0;
    endsequence

    property p_stat_answer;
        s_stat_take |=> s_frame_open;
    endproperty
    a_stat_answer: assert property (p_stat_answer)
        else $error("status frame not opened two edges after request");
    property p_auto_status;
        cmd_valid && cmd_ready && cmd_data != 8'h06 |-> ##[1:40] s_stat_take;
    endproperty
    a_auto_status: assert property (p_auto_status)
        else $error("no status request followed a command");
    property p_cmd_hold;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command dropped before it was taken");
    property p_byte_hold;
        sts_valid && !sts_ready |=>
            sts_valid && $stable(sts_data) && $stable(sts_last);
    endproperty
    a_byte_hold: assert property (p_byte_hold)
        else $error("sense byte changed before it was taken");
    property p_refuse;
        sts_valid |-> !cmd_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("command accepted during a sense frame");
    property p_rsv_err;
        sts_valid && idx_r == 2'h0 |-> !sts_data[7] && !sts_data[2];
    endproperty
    a_rsv_err: assert property (p_rsv_err)
        else $error("reserved error bit set");
    property p_rsv_pos;
        sts_valid && idx_r == 2'h1 |-> !sts_data[7] && !sts_data[4];
    endproperty
    a_rsv_pos: assert property (p_rsv_pos)
        else $error("reserved position bit set");
    property p_rsv_blk;
        sts_valid && idx_r == 2'h3 |-> sts_data[7:4] == 4'h0;
    endproperty
    a_rsv_blk: assert property (p_rsv_blk)
        else $error("upper block byte carries bits above 11");
    property p_last;
        sts_valid |-> sts_last == (idx_r == 2'h3);
    endproperty
    a_last: assert property (p_last)
        else $error("last marker not on the fourth byte");
    property p_close;
        byte_take && sts_last |=> !sts_valid && cmd_ready;
    endproperty
    a_close: assert property (p_close)
        else $error("link not idle after the last sense byte");
endmodule : tss_link_sva
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench joining host end and tape interface end
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
        num_errors++; \
        $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); \
    end \
end
module tb_top;
    typedef struct packed {
        logic [7:0] err;
        logic [7:0] pos;
        logic [11:0] blk;
        logic tr;
        logic un;
        logic ctr;
    } tss_exp_t;
    // short wait keeps the run brief
    localparam int EOT_CYC = 10;
    localparam logic [7:0] ERR_BIT [10] = '{8'h01, 8'h01, 8'h02, 8'h08,
        8'h10, 8'h20, 8'h40, 8'h40, 8'h00, 8'h00};
    localparam logic [1:0] PS_BIT [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    localparam logic [7:0] BAD0 [5] = '{8'h0C, 8'h14, 8'h15, 8'h16, 8'h17};
    localparam logic [7:0] BAD1 [4] = '{8'h05, 8'h07, 8'h08, 8'h09};
    localparam logic [15:0] WC [8] = '{16'h00FF, 16'h0100, 16'h01FE,
        16'h01FF, 16'h02FF, 16'h0300, 16'h03FE, 16'h03FF};
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_cmd = 8'h00;
    logic dtype = 1'b0;
    logic unk_len = 1'b0;
    logic [9:0] ev = 10'h000;
    logic op_done = 1'b0;
    logic [3:0] trk = 4'h0;
    logic [11:0] blk = 12'h000;
    logic [15:0] wr_count = 16'h0000;
    logic [15:0] wr_block = 16'h0000;
    logic req_ready, sense_valid, blk_tr, sense_un, extra_ok, in_rng, d_stb;
    logic [7:0] s_err, s_pos, eb, d_cmd;
    logic [7:0] last_cmd = 8'h00;
    int stb_n = 0;
    int n_work = 0;
    logic [11:0] s_blk;
    logic [15:0] exp_count;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 38;
    int cyc = 0;
    int n = 0;
    tss_exp_t e;
    tss_exp_t exp_q[$];

    always #5 mclk_i = ~mclk_i;

    tss_link_if link ();
    tss_dev u_tss_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link),
        .drive_type_i(dtype), .blk_not_found_i(ev[0]),
        .blk_no_follow_i(ev[1]), .drive_ended_xfer_i(ev[2]),
        .invalid_cmd_i(ev[3]), .protocol_err_i(ev[4]),
        .no_data_timeout_i(ev[5]), .bot_logical_i(ev[6]),
        .bot_physical_i(ev[7]), .file_mark_i(ev[8]), .eot_logical_i(ev[9]),
        .op_done_i(op_done), .track_i(trk), .block_i(blk),
        .cmd_stb_o(d_stb), .cmd_o(d_cmd));
    tss_host #(.EOT_WAIT_CYC(EOT_CYC)) u_tss_host (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .link(link), .req_valid_i(req_valid),
        .req_cmd_i(req_cmd), .drive_type_i(dtype), .unknown_len_i(unk_len),
        .req_ready_o(req_ready), .sense_valid_o(sense_valid),
        .sense_err_o(s_err), .sense_pos_o(s_pos), .sense_blk_o(s_blk),
        .blk_trusted_o(blk_tr), .sense_untrusted_o(sense_un),
        .wr_count_i(wr_count), .wr_block_i(wr_block),
        .exp_count_o(exp_count), .extra_ok_o(extra_ok));
    tss_link_sva u_tss_link_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data),
        .cmd_ready(link.cmd_ready), .sts_valid(link.sts_valid),
        .sts_data(link.sts_data), .sts_last(link.sts_last),
        .sts_ready(link.sts_ready));

    function automatic tss_exp_t mk(input logic [7:0] err,
        input logic [1:0] ps, input logic ctr = 1'b0,
        input logic tr = 1'b0, input logic un = 1'b0);
        return '{err, {1'b0, ps, 1'b0, trk}, blk, tr, un, ctr};
    endfunction : mk

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // note the expected frame first, then hand the command to the host
    task automatic request(input logic [7:0] c, input tss_exp_t x);
        int k;
        exp_q.push_back(x);
        if (c != 8'h06) begin
            last_cmd = c;
            n_work++;
        end
        @(posedge mclk_i);
        #1 req_cmd = c;
        req_valid = 1'b1;
        do @(posedge mclk_i); while (req_ready !== 1'b1);
        #1 req_valid = 1'b0;
        k = 0;
        while (exp_q.size() != 0 && k < 200) begin
            @(posedge mclk_i);
            k++;
        end
        // a frame that never came counts against the run
        if (exp_q.size() != 0) begin
            num_errors++;
        end
        #1;
    endtask : request

    task automatic set_pos();
        int r;
        r = $random(seed);
        @(posedge mclk_i);
        #1 trk = r[3:0];
        blk = r[15:4];
        op_done = 1'b1;
        @(posedge mclk_i);
        #1 op_done = 1'b0;
    endtask : set_pos

    task automatic fire(input int i);
        @(posedge mclk_i);
        #1 ev[i] = 1'b1;
        @(posedge mclk_i);
        #1 ev[i] = 1'b0;
    endtask : fire

    always @(posedge mclk_i) begin
        if (sense_valid === 1'b1) begin
            `CHK("sense expected", 1'b1, exp_q.size() != 0)
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                `CHK("err byte", e.err, s_err)
                `CHK("pos byte", e.pos, s_pos)
                `CHK("block", e.blk, s_blk)
                `CHK("drive cmd", last_cmd, d_cmd)
                if (e.ctr) begin
                    `CHK("trusted", e.tr, blk_tr)
                    `CHK("untrusted", e.un, sense_un)
                end
            end
        end
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (d_stb === 1'b1) begin
            stb_n++;
        end
        if (cyc == 30000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        for (int t = 0; t < 2; t++) begin
            @(posedge mclk_i);
            #1 dtype = (t == 1);
            // each event alone; wrong-type beginning-of-tape must stay clear
            for (int i = 0; i < 10; i++) begin
                set_pos();
                fire(i);
                eb = (i < 6 || i == 6 + t) ? ERR_BIT[i] : 8'h00;
                request(8'h06, mk(eb, PS_BIT[i]));
                request(t == 1 ? 8'h0C : 8'h07, mk(8'h00, 2'h0));
            end
            for (int k = 0; k < 5 - t; k++)
                request(t == 1 ? BAD1[k] : BAD0[k], mk(8'h10, 2'h0));
            for (int f = 0; f < 2; f++) begin
                ev[8] = (f == 1);
                request(8'h04, mk(8'h00, {1'b0, f == 1}, 1'b1, f == 1,
                    f == 1 && t == 1));
                ev[8] = 1'b0;
            end
            for (int u = 0; u < 2; u++) begin
                unk_len = (u == 1);
                fork
                    request(8'h80, mk(8'h00, 2'h0));
                    begin
                        n = 0;
                        do @(posedge mclk_i); while (!(req_valid && req_ready));
                        do begin
                            @(posedge mclk_i);
                            n++;
                        end while (link.cmd_valid !== 1'b1 && n < 100);
                    end
                join
                `CHK("eot wait", t == 0 && u == 1, n >= EOT_CYC)
            end
            for (int k = 0; k < 8; k++) begin
                @(posedge mclk_i);
                #1 wr_count = WC[k];
                wr_block = (k % 2 == 1) ? 16'hFFFF : 16'hFFFE;
                in_rng = (WC[k] >= 16'h0100 && WC[k] <= 16'h01FE) ||
                    (WC[k] >= 16'h0300 && WC[k] <= 16'h03FE);
                repeat (2) @(posedge mclk_i);
                `CHK("count", (t == 1 && in_rng) ? WC[k] + 16'h0200 : WC[k],
                    exp_count)
                `CHK("extra", t == 1 && k % 2 == 1, extra_ok)
            end
        end
        `CHK("strobes", n_work, stb_n)
        conclude();
    end
endmodule : tb_top
`default_nettype wire
